// ===== include/scp_map.svh
// scp_map.svh: offsets, field positions, reset values and counts of the serial cpu port
// assumes: included by bare name; definitions only
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// register byte offsets on the plain register port
`define SCP_CTRL_OFS 8'h00
`define SCP_STAT_OFS 8'h04
`define SCP_DATA_OFS 8'h08

// control fields and reset value (select pin idles deselected)
`define SCP_CTRL_MEN 0
`define SCP_CTRL_MCLK 1
`define SCP_CTRL_MDO 2
`define SCP_CTRL_MSELN 3
`define SCP_CTRL_RST 4'h8

// status fields
`define SCP_STAT_DIN 0
`define SCP_STAT_BOOTING 1
`define SCP_STAT_BOOTED 2
`define SCP_STAT_CFG 4

// strap code that selects booting from the serial memory
`define SCP_BOOT_CFG 3'h1

// boot clock timing and boot length in bytes
`define SCP_CLK_NS 10
`define SCP_BOOT_SCK_NS 80
`define SCP_BOOT_DIV (`SCP_BOOT_SCK_NS / `SCP_CLK_NS)
`define SCP_BOOT_BYTES 16

// slave frame layout in link clocks
`define SCP_CMD_LAST 5'h07
`define SCP_PAD_LAST 5'h07
`define SCP_DATA_LAST 5'h1f
`endif

// ===== include/scp_pkg.sv
// scp_pkg.sv: types of the serial cpu port
// assumes: compiled before the design modules
package scp_pkg;
	timeunit 1ns;
	timeprecision 1ps;
	typedef enum logic [1:0] {SCP_ROLE_SLAVE, SCP_ROLE_MASTER, SCP_ROLE_BOOT} scp_role_t;
	typedef enum logic [1:0] {SCP_BOOT_WAIT, SCP_BOOT_LOAD, SCP_BOOT_END} scp_boot_t;
	typedef enum logic [1:0] {SCP_PH_CMD, SCP_PH_PAD, SCP_PH_DATA, SCP_PH_END} scp_phase_t;
endpackage : scp_pkg

// ===== hdl/scp_link.sv
// scp_link.sv: slave frame engine clocked by the external master's serial clock
// assumes: frame_end high outside frames; rd_word stable from the read request to the end of padding
`include "scp_map.svh"
module scp_link (
	input wire logic link_clk,
	input wire logic rst,
	input wire logic frame_end,
	input wire logic serial_in,
	input wire logic [31:0] rd_word,
	output logic serial_out,
	output logic out_en,
	output logic req_tgl,
	output logic req_wr,
	output logic [5:0] req_idx,
	output logic [31:0] req_data
);
	timeunit 1ns;
	timeprecision 1ps;
	scp_pkg::scp_phase_t ph_q, ph_d;
	logic [4:0] cnt_q, cnt_d;
	logic [31:0] sh_q, sh_d;
	logic wr_q, wr_d;
	logic [5:0] idx_q, idx_d;
	logic [31:0] dat_q, dat_d;
	logic tgl_q, tgl_d;
	logic out_q, out_d;

	////////////////////////////////////////////////////////////////////////
	// frame sequencing: command byte, padding on reads, 32 data bits
	always_comb begin
		ph_d = ph_q;
		cnt_d = cnt_q + 5'h01;
		sh_d = {sh_q[30:0], serial_in}; // sampled on link rising edge
		wr_d = wr_q;
		idx_d = idx_q;
		dat_d = dat_q;
		tgl_d = tgl_q;
		unique case (ph_q)
			scp_pkg::SCP_PH_CMD: begin
				if (cnt_q == `SCP_CMD_LAST) begin
					wr_d = sh_q[6];
					idx_d = {sh_q[4:0], serial_in};
					cnt_d = 5'h00;
					ph_d = sh_q[6] ? scp_pkg::SCP_PH_DATA : scp_pkg::SCP_PH_PAD;
					if (!sh_q[6]) begin
						tgl_d = ~tgl_q; // read request, padding hides the crossing
					end
				end
			end
			scp_pkg::SCP_PH_PAD: begin
				if (cnt_q == `SCP_PAD_LAST) begin
					sh_d = rd_word;
					cnt_d = 5'h00;
					ph_d = scp_pkg::SCP_PH_DATA;
				end
			end
			scp_pkg::SCP_PH_DATA: begin
				if (cnt_q == `SCP_DATA_LAST) begin
					ph_d = scp_pkg::SCP_PH_END;
					if (wr_q) begin
						dat_d = {sh_q[30:0], serial_in};
						tgl_d = ~tgl_q; // write request
					end
				end
			end
			scp_pkg::SCP_PH_END: begin
				cnt_d = cnt_q; // extra clocks are ignored
				sh_d = sh_q;
			end
		endcase
		out_d = (ph_q == scp_pkg::SCP_PH_DATA && !wr_q) ? sh_q[31] : 1'b0;
	end

	// per-frame state dies with the select, link clock may stop
	always_ff @(posedge link_clk or posedge frame_end) begin
		if (frame_end) begin
			ph_q <= scp_pkg::SCP_PH_CMD;
			cnt_q <= 5'h00;
			sh_q <= 32'h0000_0000;
		end else begin
			ph_q <= ph_d; // pin clock runs the transfer
			cnt_q <= cnt_d;
			sh_q <= sh_d;
		end
	end

	// request words outlive the frame so the core can still fetch them
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			wr_q <= 1'b0;
			idx_q <= 6'h00;
			dat_q <= 32'h0000_0000;
			tgl_q <= 1'b0;
		end else begin
			wr_q <= wr_d;
			idx_q <= idx_d;
			dat_q <= dat_d;
			tgl_q <= tgl_d;
		end
	end

	// launch on falling edge, master samples on the next rising one
	always_ff @(negedge link_clk or posedge frame_end) begin
		if (frame_end) begin
			out_q <= 1'b0;
		end else begin
			out_q <= out_d;
		end
	end

	assign serial_out = out_q;
	assign out_en = ~frame_end; // high impedance while deselected
	assign req_tgl = tgl_q;
	assign req_wr = wr_q;
	assign req_idx = idx_q;
	assign req_data = dat_q;

	////////////////////////////////////////////////////////////////////////
	tx_load_a: assert property (@(posedge link_clk) disable iff (frame_end)
		(ph_q == scp_pkg::SCP_PH_PAD && cnt_q == `SCP_PAD_LAST) |=> (sh_q == $past(rd_word)))
		else $error("read word not loaded at end of padding");
	read_req_a: assert property (@(posedge link_clk) disable iff (frame_end)
		(ph_q == scp_pkg::SCP_PH_CMD && cnt_q == `SCP_CMD_LAST && !sh_q[6])
		|=> (ph_q == scp_pkg::SCP_PH_PAD && tgl_q != $past(tgl_q)))
		else $error("read command not decoded after eight bits");
endmodule : scp_link

// ===== hdl/scp_top.sv
// scp_top.sv: serial cpu port with slave, software master and boot roles
// assumes: clk 100 MHz, srst synchronous; pins and link clock asynchronous to clk
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`include "scp_map.svh"
module scp_top #(
	parameter int BOOT_DIV = `SCP_BOOT_DIV,
	parameter int BOOT_BYTES = `SCP_BOOT_BYTES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [2:0] cpu_boot_config,
	input wire logic serial_clk_i,
	output logic serial_clk_o,
	output logic serial_clk_oe,
	input wire logic host_serial_in,
	output logic serial_dout_o,
	output logic serial_dout_oe,
	input wire logic host_serial_select_n_i,
	output logic host_serial_select_n_o,
	output logic host_serial_select_n_oe,
	output logic [7:0] boot_byte,
	output logic boot_byte_valid,
	output logic boot_done
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] DIV_LAST = 8'(BOOT_DIV - 1);
	localparam logic [7:0] DIV_HALF = 8'(BOOT_DIV / 2);
	localparam logic [15:0] BYTES_LAST = 16'(BOOT_BYTES - 1);

	// register read decode, shared by the bus and the slave frames
	function automatic logic [31:0] reg_read(input logic [7:0] a, input logic [3:0] ctl,
		input logic [31:0] stat, input logic [31:0] dat);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (a == `SCP_CTRL_OFS) begin
			v[3:0] = ctl;
		end else if (a == `SCP_STAT_OFS) begin
			v = stat;
		end else if (a == `SCP_DATA_OFS) begin
			v = dat;
		end
		return v;
	endfunction : reg_read

	////////////////////////////////////////////////////////////////////////
	// synchronisers for pins and the slave request toggle
	logic din_s1_q, din_s2_q;
	logic [2:0] cfg_s1_q, cfg_s2_q;
	logic tg_s1_q, tg_s2_q, tg_s3_q;
	logic lk_tgl, lk_wr, lk_out, lk_oe;
	logic [5:0] lk_idx;
	logic [31:0] lk_data;
	logic req_edge;

	always_ff @(posedge clk) begin
		if (srst) begin
			din_s1_q <= 1'b0;
			din_s2_q <= 1'b0;
			cfg_s1_q <= 3'h0;
			cfg_s2_q <= 3'h0;
			tg_s1_q <= 1'b0;
			tg_s2_q <= 1'b0;
			tg_s3_q <= 1'b0;
		end else begin
			din_s1_q <= host_serial_in;
			din_s2_q <= din_s1_q;
			cfg_s1_q <= cpu_boot_config;
			cfg_s2_q <= cfg_s1_q;
			tg_s1_q <= lk_tgl;
			tg_s2_q <= tg_s1_q;
			tg_s3_q <= tg_s2_q;
		end
	end

	assign req_edge = tg_s2_q ^ tg_s3_q;

	////////////////////////////////////////////////////////////////////////
	// boot loader: strap capture, divided clock, byte assembly
	scp_pkg::scp_boot_t st_q, st_d;
	logic [1:0] wait_q, wait_d;
	logic [2:0] cfg_q, cfg_d;
	logic [7:0] div_q, div_d;
	logic sck_q, sck_d;
	logic [2:0] bitc_q, bitc_d;
	logic [7:0] bsh_q, bsh_d;
	logic [15:0] bytec_q, bytec_d;
	logic [7:0] bbyte_q, bbyte_d;
	logic bval_q, bval_d;
	logic booted_q, booted_d;

	always_comb begin
		st_d = st_q;
		wait_d = wait_q;
		cfg_d = cfg_q;
		div_d = div_q;
		sck_d = sck_q;
		bitc_d = bitc_q;
		bsh_d = bsh_q;
		bytec_d = bytec_q;
		bbyte_d = bbyte_q;
		bval_d = 1'b0;
		booted_d = booted_q;
		unique case (st_q)
			scp_pkg::SCP_BOOT_WAIT: begin
				// two cycles let the synchroniser flush its reset value
				wait_d = wait_q + 2'h1;
				if (wait_q == 2'h2) begin
					cfg_d = cfg_s2_q;
					st_d = (cfg_s2_q == `SCP_BOOT_CFG) ? scp_pkg::SCP_BOOT_LOAD
						: scp_pkg::SCP_BOOT_END;
				end
			end
			scp_pkg::SCP_BOOT_LOAD: begin
				div_d = (div_q == DIV_LAST) ? 8'h00 : div_q + 8'h01;
				sck_d = (div_d >= DIV_HALF);
				// sample late in the high phase to cover synchroniser delay
				if (div_q == DIV_LAST) begin
					bsh_d = {bsh_q[6:0], din_s2_q};
					bitc_d = bitc_q + 3'h1;
					if (bitc_q == 3'h7) begin
						bbyte_d = {bsh_q[6:0], din_s2_q};
						bval_d = 1'b1;
						bytec_d = bytec_q + 16'h0001;
						if (bytec_q == BYTES_LAST) begin
							st_d = scp_pkg::SCP_BOOT_END; // releases select
							booted_d = 1'b1;
						end
					end
				end
			end
			scp_pkg::SCP_BOOT_END: begin
				sck_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_q <= scp_pkg::SCP_BOOT_WAIT;
			wait_q <= 2'h0;
			cfg_q <= 3'h0;
			div_q <= 8'h00;
			sck_q <= 1'b0;
			bitc_q <= 3'h0;
			bsh_q <= 8'h00;
			bytec_q <= 16'h0000;
			bbyte_q <= 8'h00;
			bval_q <= 1'b0;
			booted_q <= 1'b0;
		end else begin
			st_q <= st_d;
			wait_q <= wait_d;
			cfg_q <= cfg_d;
			div_q <= div_d;
			sck_q <= sck_d;
			bitc_q <= bitc_d;
			bsh_q <= bsh_d;
			bytec_q <= bytec_d;
			bbyte_q <= bbyte_d;
			bval_q <= bval_d;
			booted_q <= booted_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register file; bus writes win, a slave write waits one free cycle
	logic [3:0] ctrl_q, ctrl_d;
	logic [31:0] data_q, data_d;
	logic [31:0] rdata_q, rdata_d;
	logic [31:0] rdw_q, rdw_d;
	logic pend_q, pend_d;
	logic [5:0] pidx_q, pidx_d;
	logic [31:0] pdat_q, pdat_d;
	scp_pkg::scp_role_t role_q, role_w;
	logic [31:0] stat_w;
	logic [7:0] w_addr;
	logic [31:0] w_dat;
	logic w_en;

	always_comb begin
		stat_w = 32'h0000_0000;
		stat_w[`SCP_STAT_DIN] = din_s2_q; // live input level
		stat_w[`SCP_STAT_BOOTING] = (st_q == scp_pkg::SCP_BOOT_LOAD);
		stat_w[`SCP_STAT_BOOTED] = booted_q;
		stat_w[`SCP_STAT_CFG +: 3] = cfg_q;
		if (st_q == scp_pkg::SCP_BOOT_LOAD) begin
			role_w = scp_pkg::SCP_ROLE_BOOT;
		end else if (ctrl_q[`SCP_CTRL_MEN]) begin
			role_w = scp_pkg::SCP_ROLE_MASTER;
		end else begin
			role_w = scp_pkg::SCP_ROLE_SLAVE;
		end
		w_en = wr | pend_q;
		w_addr = wr ? addr : {pidx_q, 2'b00};
		w_dat = wr ? wdata : pdat_q;
	end

	always_comb begin
		ctrl_d = ctrl_q;
		data_d = data_q;
		rdw_d = rdw_q;
		pend_d = pend_q & wr;
		pidx_d = pidx_q;
		pdat_d = pdat_q;
		rdata_d = 32'h0000_0000; // read data stand for one cycle only
		if (rd) begin
			rdata_d = reg_read(addr, ctrl_q, stat_w, data_q);
		end
		if (w_en && w_addr == `SCP_CTRL_OFS) begin
			ctrl_d = w_dat[3:0];
		end else if (w_en && w_addr == `SCP_DATA_OFS) begin
			data_d = w_dat;
		end
		if (req_edge) begin
			if (lk_wr) begin
				pend_d = 1'b1;
				pidx_d = lk_idx;
				pdat_d = lk_data;
			end else begin
				rdw_d = reg_read({lk_idx, 2'b00}, ctrl_q, stat_w, data_q);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= `SCP_CTRL_RST;
			data_q <= 32'h0000_0000;
			rdata_q <= 32'h0000_0000;
			rdw_q <= 32'h0000_0000;
			pend_q <= 1'b0;
			pidx_q <= 6'h00;
			pdat_q <= 32'h0000_0000;
			role_q <= scp_pkg::SCP_ROLE_SLAVE;
		end else begin
			ctrl_q <= ctrl_d;
			data_q <= data_d;
			rdata_q <= rdata_d;
			rdw_q <= rdw_d;
			pend_q <= pend_d;
			pidx_q <= pidx_d;
			pdat_q <= pdat_d;
			role_q <= role_w;
		end
	end

	assign rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// slave frame engine; select from a register so the role mask cannot glitch
	scp_link i_scp_link (
		.link_clk(serial_clk_i),
		.rst(srst),
		.frame_end(host_serial_select_n_i | (role_q != scp_pkg::SCP_ROLE_SLAVE)),
		.serial_in(host_serial_in),
		.rd_word(rdw_q),
		.serial_out(lk_out),
		.out_en(lk_oe),
		.req_tgl(lk_tgl),
		.req_wr(lk_wr),
		.req_idx(lk_idx),
		.req_data(lk_data)
	);

	////////////////////////////////////////////////////////////////////////
	// pin muxing per role; no sequencing in master role
	assign serial_clk_o = (role_w == scp_pkg::SCP_ROLE_BOOT) ? sck_q : ctrl_q[`SCP_CTRL_MCLK];
	assign serial_clk_oe = (role_w != scp_pkg::SCP_ROLE_SLAVE);
	assign host_serial_select_n_o = (role_w == scp_pkg::SCP_ROLE_BOOT) ? 1'b0 : ctrl_q[`SCP_CTRL_MSELN];
	assign host_serial_select_n_oe = (role_w != scp_pkg::SCP_ROLE_SLAVE);
	assign serial_dout_o = (role_w == scp_pkg::SCP_ROLE_MASTER) ? ctrl_q[`SCP_CTRL_MDO] : lk_out;
	assign serial_dout_oe = (role_w == scp_pkg::SCP_ROLE_MASTER) |
		((role_w == scp_pkg::SCP_ROLE_SLAVE) & lk_oe); // unused in boot role
	assign boot_byte = bbyte_q;
	assign boot_byte_valid = bval_q;
	assign boot_done = (st_q == scp_pkg::SCP_BOOT_END);

	////////////////////////////////////////////////////////////////////////
	sequence ctrl_wr_s;
		wr && addr == `SCP_CTRL_OFS && wdata[`SCP_CTRL_MEN] && st_q != scp_pkg::SCP_BOOT_LOAD;
	endsequence
	sequence byte_end_s;
		st_q == scp_pkg::SCP_BOOT_LOAD && div_q == DIV_LAST && bitc_q == 3'h7;
	endsequence

	master_pins_a: assert property (@(posedge clk) disable iff (srst)
		ctrl_wr_s |=> (serial_clk_o == $past(wdata[`SCP_CTRL_MCLK])
		&& serial_dout_o == $past(wdata[`SCP_CTRL_MDO])
		&& host_serial_select_n_o == $past(wdata[`SCP_CTRL_MSELN]) && serial_dout_oe))
		else $error("master pins do not follow control write");
	din_read_a: assert property (@(posedge clk) disable iff (srst)
		(rd && addr == `SCP_STAT_OFS) |=> (rdata[`SCP_STAT_DIN] == $past(din_s2_q)))
		else $error("status does not show input level");
	boot_sel_a: assert property (@(posedge clk) disable iff (srst)
		(st_q == scp_pkg::SCP_BOOT_LOAD) |-> (!host_serial_select_n_o && host_serial_select_n_oe))
		else $error("select not driven during boot");
	boot_clk_a: assert property (@(posedge clk) disable iff (srst)
		($rose(sck_q) && st_q == scp_pkg::SCP_BOOT_LOAD) |-> sck_q [*4] ##1 !sck_q)
		else $error("boot clock high phase wrong");
	boot_dout_a: assert property (@(posedge clk) disable iff (srst)
		(st_q == scp_pkg::SCP_BOOT_LOAD) |-> !serial_dout_oe)
		else $error("serial output driven in boot role");
	boot_byte_a: assert property (@(posedge clk) disable iff (srst)
		byte_end_s |=> (boot_byte_valid && boot_byte[0] == $past(din_s2_q)))
		else $error("boot byte not delivered");
	boot_strap_a: assert property (@(posedge clk) disable iff (srst)
		(st_q == scp_pkg::SCP_BOOT_LOAD) |-> (cfg_q == `SCP_BOOT_CFG))
		else $error("boot without strap");
	slave_hiz_a: assert property (@(posedge clk) disable iff (srst)
		(host_serial_select_n_i && role_w == scp_pkg::SCP_ROLE_SLAVE) |-> !serial_dout_oe)
		else $error("deselected slave drives output");
	slave_rd_a: assert property (@(posedge clk) disable iff (srst)
		(req_edge && !lk_wr) |=> (rdw_q == $past(reg_read({lk_idx, 2'b00}, ctrl_q, stat_w, data_q))))
		else $error("slave read word not fetched");
endmodule : scp_top

// ===== sim/scp_host_model.sv
// scp_host_model.sv: external serial master and serial boot memory at the port pins
// assumes: the bench resolves the shared pins; link clock stands still outside frames
module scp_host_model #(
	parameter logic [15:0] MEM = 16'h3cc3
) (
	input wire logic clk_pin,
	input wire logic sel_pin,
	input wire logic dout,
	input wire logic dout_oe,
	output logic sclk,
	output logic sel_n,
	output logic din
);
	timeunit 1ns;
	timeprecision 1ps;
	logic host_bit;
	logic mem_on;
	logic [3:0] mem_idx;

	// idle: no clock, not selecting
	initial begin
		sclk = 1'b0;
		sel_n = 1'b1;
		host_bit = 1'b1;
	end

	// memory answers only while the device, not this master, selects it
	assign mem_on = ~sel_pin & sel_n;
	assign din = mem_on ? MEM[4'hf - mem_idx] : host_bit;

	// bit pointer parked while deselected; one process so it has one driver
	// next bit launched on the falling edge, well ahead of the sample
	always @(negedge clk_pin or posedge sel_pin) begin
		if (sel_pin) begin
			mem_idx = 4'h0;
		end else if (mem_on) begin
			mem_idx = mem_idx + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// one frame at a 48 ns link clock; en low sends the clocks deselected
	task automatic frame(input logic wr, input logic [5:0] idx, input logic [31:0] wd, input logic en,
		output logic [31:0] rdv);
		logic [39:0] sh;
		sh = {wr, 1'b0, idx, wr ? wd : 32'h0};
		rdv = 32'h0;
		sel_n = ~en;
		for (int i = 0; i < (wr ? 40 : 48); i++) begin
			host_bit = (i < 40) ? sh[39 - i] : ~host_bit;
			#24 sclk = 1'b1;
			if (!wr && i >= 16) begin
				rdv = {rdv[30:0], dout_oe ? dout : 1'bx};
			end
			#24 sclk = 1'b0;
		end
		#24 sel_n = 1'b1;
		// released line must not keep showing the last bit
		host_bit = ~host_bit;
		#200;
	endtask : frame

	// level shown on the data pin outside frames, read back in master role
	task automatic drive_din(input logic b);
		host_bit = b;
	endtask : drive_din
endmodule : scp_host_model

// ===== sim/test_serial_cpu_port.sv
// test_serial_cpu_port.sv: self-checking bench of the serial cpu port
// assumes: scp_top and scp_host_model compiled first; map header on the include path
`include "scp_map.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module test_serial_cpu_port;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, srst, wr, rd, bsel, slave_mode;
	logic [7:0] addr, boot_byte;
	logic [31:0] wdata, rdata, d;
	logic [2:0] cpu_boot_config;
	logic serial_clk_o, serial_clk_oe, serial_dout_o, serial_dout_oe;
	logic host_serial_select_n_o, host_serial_select_n_oe, boot_byte_valid, boot_done;
	logic m_sclk, m_sel_n, din, clk_pin, sel_pin;
	logic [7:0] boot_q[$];
	int checks = 0;
	int failures = 0;
	int cyc = 0;

	// shared pins resolved from the device's output enables
	assign clk_pin = serial_clk_oe ? serial_clk_o : m_sclk;
	assign sel_pin = host_serial_select_n_oe ? host_serial_select_n_o : m_sel_n;

	scp_top #(.BOOT_DIV(8), .BOOT_BYTES(2)) i_scp_top (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .cpu_boot_config(cpu_boot_config), .serial_clk_i(clk_pin),
		.serial_clk_o(serial_clk_o), .serial_clk_oe(serial_clk_oe), .host_serial_in(din),
		.serial_dout_o(serial_dout_o), .serial_dout_oe(serial_dout_oe), .host_serial_select_n_i(sel_pin),
		.host_serial_select_n_o(host_serial_select_n_o), .host_serial_select_n_oe(host_serial_select_n_oe),
		.boot_byte(boot_byte), .boot_byte_valid(boot_byte_valid), .boot_done(boot_done));
	scp_host_model i_scp_host_model (.clk_pin(clk_pin), .sel_pin(sel_pin), .dout(serial_dout_o),
		.dout_oe(serial_dout_oe), .sclk(m_sclk), .sel_n(m_sel_n), .din(din));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// hang guard, several times the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			tally_and_finish();
		end
	end

	// sampled mid-cycle so design updates have landed
	always @(negedge clk) begin
		if (boot_byte_valid === 1'b1) begin
			boot_q.push_back(boot_byte);
		end
		if (slave_mode && sel_pin === 1'b1 && !srst) `CHK(serial_dout_oe, 1'b0)
	end

	////////////////////////////////////////////////////////////////////////
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : bus_rd

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	task automatic do_reset(input logic [2:0] strap);
		cpu_boot_config <= strap;
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		#1;
	endtask : do_reset

	task automatic tally_and_finish;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////////
	initial begin
		srst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		cpu_boot_config = 3'h0;
		slave_mode = 1'b1;
		do_reset(3'h0);
		// reset state, read-only and unmapped places
		`CHK({serial_clk_oe, host_serial_select_n_oe}, 2'h0)
		bus_rd(`SCP_CTRL_OFS, d);
		`CHK(d, {28'h0, `SCP_CTRL_RST})
		bus_wr(`SCP_STAT_OFS, 32'hffffffff);
		bus_rd(`SCP_STAT_OFS, d);
		`CHK(d[`SCP_STAT_CFG +: 3], 3'h0)
		bus_rd(8'h0c, d);
		`CHK(d, 32'h0)
		$display("test reset done");
		// master role: every pin combination, input level read back
		slave_mode = 1'b0;
		for (int v = 0; v < 8; v++) begin
			bus_wr(`SCP_CTRL_OFS, {28'h0, v[2:0], 1'b1});
			settle(2);
			`CHK({host_serial_select_n_o, serial_dout_o, serial_clk_o}, v[2:0])
			`CHK({host_serial_select_n_oe, serial_dout_oe, serial_clk_oe}, 3'h7)
			if (v[2]) begin
				i_scp_host_model.drive_din(v[0]);
				settle(4);
				bus_rd(`SCP_STAT_OFS, d);
				`CHK(d[`SCP_STAT_DIN], v[0])
			end
		end
		bus_wr(`SCP_CTRL_OFS, {28'h0, `SCP_CTRL_RST});
		settle(4);
		slave_mode = 1'b1;
		$display("test master done");
		// slave role: write, read back both ways, deselected traffic ignored
		i_scp_host_model.frame(1'b1, 6'h02, 32'h5a3c9617, 1'b1, d);
		settle(10);
		bus_rd(`SCP_DATA_OFS, d);
		`CHK(d, 32'h5a3c9617)
		bus_wr(`SCP_DATA_OFS, 32'h1234abcd);
		i_scp_host_model.frame(1'b0, 6'h02, 32'h0, 1'b1, d);
		`CHK(d, 32'h1234abcd)
		i_scp_host_model.frame(1'b0, 6'h00, 32'h0, 1'b1, d);
		`CHK(d, {28'h0, `SCP_CTRL_RST})
		i_scp_host_model.frame(1'b1, 6'h02, 32'hffff0000, 1'b0, d);
		settle(10);
		bus_rd(`SCP_DATA_OFS, d);
		`CHK(d, 32'h1234abcd)
		$display("test slave done");
		// every strap code; only the boot code loads from the memory
		slave_mode = 1'b0;
		for (int s = 0; s < 8; s++) begin
			bsel = (s == 1);
			boot_q.delete();
			do_reset(s[2:0]);
			settle(6);
			`CHK(host_serial_select_n_oe, bsel)
			if (bsel) `CHK({host_serial_select_n_o, serial_clk_oe, serial_dout_oe}, 3'h2)
			bus_rd(`SCP_STAT_OFS, d);
			`CHK(d[`SCP_STAT_BOOTING], bsel)
			settle(200);
			`CHK({boot_done, host_serial_select_n_oe}, 2'h2)
			`CHK(boot_q.size(), bsel ? 2 : 0)
			if (bsel) `CHK({boot_q[0], boot_q[1]}, 16'h3cc3)
			bus_rd(`SCP_STAT_OFS, d);
			`CHK(d[`SCP_STAT_CFG +: 3], s[2:0])
			`CHK({d[`SCP_STAT_BOOTED], d[`SCP_STAT_BOOTING]}, {bsel, 1'b0})
		end
		$display("test boot done");
		tally_and_finish();
	end
endmodule : test_serial_cpu_port
